// ---- osa_pkg.sv ----
// Constants, register map and types of the oversampling scan averager
package osa_pkg;

   // ============================================================
   // Data widths
   localparam int unsigned DATA_W  = 16;
   localparam int unsigned ACC_W   = 30;
   localparam int unsigned CNT_W   = 15;
   localparam int unsigned SHIFT_W = 4;
   localparam int unsigned PACE_W  = 22;

   // ============================================================
   // Oversampling limits
   localparam logic [14:0] OS_ONE = 15'h0001;
   localparam logic [14:0] OS_MIN = 15'h0002;
   localparam logic [14:0] OS_MAX = 15'h4000;

   // ============================================================
   // Timing
   localparam int unsigned CLOCK_MHZ   = 200;
   localparam int unsigned MAINS50_US  = 20000;
   localparam int unsigned MAINS60_US  = 16666;
   localparam int unsigned CONV_NS     = 1000;
   localparam int unsigned MAINS50_CYC = MAINS50_US * CLOCK_MHZ;
   localparam int unsigned MAINS60_CYC = MAINS60_US * CLOCK_MHZ;
   localparam int unsigned CONV_CYC    = (CONV_NS * CLOCK_MHZ + 999) / 1000;

   // ============================================================
   // Register byte offsets
   localparam logic [11:0] OFS_CTRL   = 12'h000;
   localparam logic [11:0] OFS_OSCNT  = 12'h004;
   localparam logic [11:0] OFS_LEN    = 12'h008;
   localparam logic [11:0] OFS_STAT   = 12'h00C;
   localparam logic [11:0] OFS_RESULT = 12'h010;
   localparam logic [3:0]  PAGE_LIST  = 4'h1;
   localparam logic [3:0]  PAGE_CJ    = 4'h2;

   // ============================================================
   // Field positions
   localparam int unsigned CTRL_GO     = 0;
   localparam int unsigned CTRL_OS     = 1;
   localparam int unsigned CTRL_LCR    = 2;
   localparam int unsigned CTRL_TCONLY = 3;
   localparam int unsigned CTRL_60HZ   = 4;
   localparam int unsigned ENT_CH_LSB  = 0;
   localparam int unsigned ENT_GN_LSB  = 8;
   localparam int unsigned ENT_KD_LSB  = 12;
   localparam int unsigned STAT_BUSY   = 0;
   localparam int unsigned STAT_FULL   = 1;
   localparam int unsigned STAT_IDX    = 8;

   // ============================================================
   // AHB-Lite codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'b0;

   typedef enum logic [2:0] {
      KIND_VOLT = 3'h0,
      KIND_TC   = 3'h1,
      KIND_CJ   = 3'h2,
      KIND_AZ   = 3'h3,
      KIND_DIG  = 3'h4
   } osa_kind_t;

   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_FETCH = 6'h02,
      ST_START = 6'h04,
      ST_WAIT  = 6'h08,
      ST_DIV   = 6'h10,
      ST_EMIT  = 6'h20
   } osa_state_t;

endpackage : osa_pkg

// ---- osa_acc_if.sv ----
// Link between the scan sequencer and the accumulator/divider
`timescale 1ns/1ps
interface osa_acc_if;
   import osa_pkg::*;
   logic              clear;
   logic              add;
   logic [15:0]       sample;
   logic              divGo;
   logic [14:0]       count;
   logic [3:0]        shift;
   logic              pow2;
   logic              done;
   logic [15:0]       avg;

   modport seq (output clear, add, sample, divGo, count, shift, pow2, input done, avg);
   modport acc (input clear, add, sample, divGo, count, shift, pow2, output done, avg);
endinterface : osa_acc_if

// ---- osa_accum.sv ----
// Accumulator and averaging divider for one scan entry
`timescale 1ns/1ps
module osa_accum
(
   input  wire logic clock,
   input  wire logic reset_n,
   input  wire logic clkEn,
   osa_acc_if.acc    acc
);
   import osa_pkg::*;

   logic signed [29:0] sum_r;
   logic        [29:0] quo_r;
   logic        [15:0] rem_r;
   logic        [4:0]  step_r;
   logic               busy_r;
   logic               neg_r;
   logic               done_r;
   logic        [15:0] avg_r;
   logic               goDly_r;

   // ============================================================
   // Restoring division step
   wire [16:0]         trial   = {rem_r, quo_r[ACC_W-1]};
   wire                fits    = trial >= {2'b00, acc.count};
   wire [29:0]         sumMag  = sum_r[ACC_W-1] ? 30'(-sum_r) : 30'(sum_r);
   wire signed [29:0]  shifted = sum_r >>> acc.shift;
   wire [29:0]         quoNext = {quo_r[ACC_W-2:0], fits};
   wire [15:0]         quoSign = neg_r ? 16'(-quoNext) : quoNext[15:0];

   assign acc.done = done_r;
   assign acc.avg  = avg_r;

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sum_r  <= '0;
         quo_r  <= '0;
         rem_r  <= '0;
         step_r <= '0;
         busy_r <= 1'b0;
         neg_r  <= 1'b0;
         done_r <= 1'b0;
         avg_r  <= '0;
         goDly_r <= 1'b0;
      end
      else if (clkEn)
      begin
         done_r <= 1'b0;
         // Divide one cycle late so the last sample is in the sum
         goDly_r <= acc.divGo;
         if (acc.clear)
            sum_r <= '0;
         else if (acc.add)
            sum_r <= sum_r + 30'(signed'(acc.sample)); // R12
         if (goDly_r && acc.pow2)
         begin
            avg_r  <= shifted[15:0]; // R12
            done_r <= 1'b1;
         end
         else if (goDly_r)
         begin
            quo_r  <= sumMag;
            rem_r  <= '0;
            neg_r  <= sum_r[ACC_W-1];
            step_r <= 5'(ACC_W - 1);
            busy_r <= 1'b1;
         end
         else if (busy_r)
         begin
            rem_r <= fits ? 16'(trial - {2'b00, acc.count}) : trial[15:0];
            quo_r <= quoNext;
            step_r <= step_r - 5'h01;
            if (step_r == 5'h00)
            begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
               avg_r  <= quoSign; // R5
            end
         end
      end
   end

endmodule : osa_accum

// ---- osa_scan_averager.sv ----
// Scan sequencer with oversampling, line cycle pacing and AHB-Lite registers
//
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// R1: Oversampling covers every analog entry kind
// R2: Digital entries bypass averager, read once
// R3: Oversampling factor ranges 2 to 16384
// R4: Channel and gain held during entry
// R5: Only the averaged value is returned
// R6: Oversampling off: one conversion per entry
// R7: Line rejection uses power-of-two sample counts
// R8: Conversion pacing fills one mains period
// R9: Line rejection: all analog or thermocouples
// R10: Cold junction offsets kept, software readable
// R11: Host inserts shorted channel between levels
// R12: Accumulator never overflows; exact power-of-two division
module osa_scan_averager
#(
   parameter int unsigned LIST_DEPTH     = 16,
   parameter int unsigned CJ_DEPTH       = 16,
   parameter int unsigned MAINS50_CYCLES = osa_pkg::MAINS50_CYC,
   parameter int unsigned MAINS60_CYCLES = osa_pkg::MAINS60_CYC,
   parameter int unsigned CONV_CYCLES    = osa_pkg::CONV_CYC
)
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic        clkEn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   output logic             adcStart,
   output logic [7:0]       adcChannel,
   output logic [2:0]       adcGain,
   input  wire logic        adcConvDone,
   input  wire logic [15:0] adcData,
   input  wire logic [15:0] dinPins,
   output logic             resultValid,
   output logic [15:0]      resultData,
   output logic [7:0]       resultIndex
);
   import osa_pkg::*;

   // ============================================================
   // Helpers
   function automatic logic [3:0] floorLog2(input logic [14:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 1; i < 15; i++)
         if (v[i])
            r = 4'(i);
      return r;
   endfunction : floorLog2

   function automatic logic [7:0] wordIdx(input logic [11:0] a);
      return {2'b00, a[7:2]};
   endfunction : wordIdx

   // ============================================================
   // State
   osa_state_t          state_r;
   logic [31:0]         ctrl_r;
   logic [14:0]         osCount_r;
   logic [7:0]          listLen_r;
   logic [15:0]         list_r [LIST_DEPTH];
   logic [15:0]         cjOfs_r [CJ_DEPTH];
   logic [7:0]          idx_r;
   logic [14:0]         target_r;
   logic [14:0]         taken_r;
   logic [PACE_W-1:0]   pace_r;
   logic [PACE_W-1:0]   paceCnt_r;
   logic                lcr_r;
   logic                resFull_r;
   logic [15:0]         resReg_r;
   logic                doneS1_r, doneS2_r, doneS3_r;
   logic [15:0]         dataS1_r, dataS2_r;
   logic [15:0]         dinS1_r, dinS2_r;
   logic                wrPend_r;
   logic [11:0]         wrAddr_r;
   logic                adcStart_r, resultValid_r;
   logic [7:0]          adcChannel_r, resultIndex_r;
   logic [2:0]          adcGain_r;
   logic [15:0]         resultData_r;
   logic [31:0]         hrdata_r;
   logic                hreadyout_r;

   osa_acc_if acc ();

   osa_accum u_accum
   (
      .clock   (clock),
      .reset_n (reset_n),
      .clkEn   (clkEn),
      .acc     (acc)
   );

   // ============================================================
   // Entry decode
   wire [15:0]        entry     = list_r[idx_r[3:0]];
   wire osa_kind_t    kind      = osa_kind_t'(entry[ENT_KD_LSB +: 3]);
   wire               isDigital = (kind == KIND_DIG);
   wire               osEn      = ctrl_r[CTRL_OS];
   wire [14:0]        osClamp   = (osCount_r < OS_MIN) ? OS_MIN :
                                  (osCount_r > OS_MAX) ? OS_MAX : osCount_r; // R3
   wire               lcrActive = osEn && ctrl_r[CTRL_LCR] &&
                                  (!ctrl_r[CTRL_TCONLY] || kind == KIND_TC); // R9
   wire [3:0]         lcrShift  = floorLog2(osClamp);
   wire [14:0]        lcrCount  = OS_ONE << lcrShift; // R7
   wire [14:0]        entTarget = !osEn ? OS_ONE : (lcrActive ? lcrCount : osClamp); // R1 R6
   wire [PACE_W-1:0]  mainsCyc  = ctrl_r[CTRL_60HZ] ? PACE_W'(MAINS60_CYCLES) : PACE_W'(MAINS50_CYCLES);
   wire [PACE_W-1:0]  entPace   = lcrActive ? (mainsCyc >> lcrShift) : PACE_W'(CONV_CYCLES); // R8
   wire               doneEdge  = doneS2_r && !doneS3_r;
   wire               lastSamp  = (taken_r + OS_ONE) == target_r;
   wire               lastEntry = (idx_r + 8'h01) >= listLen_r;
   wire               goReq     = wrPend_r && wrAddr_r == OFS_CTRL && hwdata[CTRL_GO];

   // ============================================================
   // Bus decode
   wire        addrPh   = hsel && hready && htrans == HTRANS_NONSEQ;
   wire [11:0] aOfs     = {haddr[11:2], 2'b00};
   wire        rdResult = addrPh && !hwrite && aOfs == OFS_RESULT;
   wire [7:0]  wIdx     = wordIdx(wrAddr_r);
   wire        wrList   = wrPend_r && wrAddr_r[11:8] == PAGE_LIST && wIdx < 8'(LIST_DEPTH);
   wire        wrCj     = wrPend_r && wrAddr_r[11:8] == PAGE_CJ && wIdx < 8'(CJ_DEPTH);
   wire [7:0]  rIdx     = wordIdx(aOfs);
   wire [31:0] statWord = {16'h0000, idx_r, 6'h00, resFull_r, state_r != ST_IDLE};
   wire [31:0] rdWord   =
      (aOfs == OFS_CTRL)   ? {27'h0, ctrl_r[4:1], 1'b0} :
      (aOfs == OFS_OSCNT)  ? {17'h0, osCount_r} :
      (aOfs == OFS_LEN)    ? {24'h0, listLen_r} :
      (aOfs == OFS_STAT)   ? statWord :
      (aOfs == OFS_RESULT) ? {16'h0, resReg_r} :
      (aOfs[11:8] == PAGE_LIST && rIdx < 8'(LIST_DEPTH)) ? {16'h0, list_r[rIdx[3:0]]} :
      (aOfs[11:8] == PAGE_CJ && rIdx < 8'(CJ_DEPTH)) ? {16'h0, cjOfs_r[rIdx[3:0]]} : 32'h0000_0000;

   // ============================================================
   // Accumulator controls
   assign acc.clear  = (state_r == ST_FETCH);
   assign acc.add    = (state_r == ST_WAIT) && doneEdge;
   assign acc.sample = dataS2_r;
   assign acc.divGo  = (state_r == ST_WAIT) && doneEdge && lastSamp;
   assign acc.count  = target_r;
   assign acc.shift  = floorLog2(target_r);
   assign acc.pow2   = (target_r & (target_r - OS_ONE)) == 15'h0000;

   // ============================================================
   // Outputs
   assign hreadyout   = hreadyout_r;
   assign hrdata      = hrdata_r;
   assign hresp       = HRESP_OKAY;
   assign adcStart    = adcStart_r;
   assign adcChannel  = adcChannel_r;
   assign adcGain     = adcGain_r;
   assign resultValid = resultValid_r;
   assign resultData  = resultData_r;
   assign resultIndex = resultIndex_r;

   // ============================================================
   // Pin synchronisers
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         {doneS1_r, doneS2_r, doneS3_r} <= 3'h0;
         {dataS1_r, dataS2_r, dinS1_r, dinS2_r} <= 64'h0;
      end
      else if (clkEn)
      begin
         {doneS1_r, doneS2_r, doneS3_r} <= {adcConvDone, doneS1_r, doneS2_r};
         {dataS1_r, dataS2_r} <= {adcData, dataS1_r};
         {dinS1_r, dinS2_r} <= {dinPins, dinS1_r};
      end
   end

   // ============================================================
   // AHB-Lite slave
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         hreadyout_r <= 1'b1;
         hrdata_r    <= 32'h0000_0000;
         wrPend_r    <= 1'b0;
         wrAddr_r    <= 12'h000;
         ctrl_r      <= 32'h0000_0000;
         osCount_r   <= OS_MIN;
         listLen_r   <= 8'h01;
      end
      else if (clkEn)
      begin
         wrPend_r <= addrPh && hwrite;
         wrAddr_r <= aOfs;
         if (addrPh && !hwrite)
            hrdata_r <= rdWord;
         if (wrPend_r && wrAddr_r == OFS_CTRL)
            ctrl_r <= {27'h0, hwdata[4:1], 1'b0};
         if (wrPend_r && wrAddr_r == OFS_OSCNT)
            osCount_r <= hwdata[14:0];
         if (wrPend_r && wrAddr_r == OFS_LEN)
            listLen_r <= hwdata[7:0];
      end
   end

   always_ff @(posedge clock)
   begin
      if (clkEn && wrList)
         list_r[wIdx[3:0]] <= hwdata[15:0];
      if (clkEn && wrCj)
         cjOfs_r[wIdx[3:0]] <= hwdata[15:0]; // R10
   end

   // ============================================================
   // Scan sequencer
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_r       <= ST_IDLE;
         idx_r         <= 8'h00;
         target_r      <= OS_ONE;
         taken_r       <= 15'h0000;
         pace_r        <= '0;
         paceCnt_r     <= '0;
         lcr_r         <= 1'b0;
         adcStart_r    <= 1'b0;
         adcChannel_r  <= 8'h00;
         adcGain_r     <= 3'h0;
         resultValid_r <= 1'b0;
         resultData_r  <= 16'h0000;
         resultIndex_r <= 8'h00;
         resFull_r     <= 1'b0;
         resReg_r      <= 16'h0000;
      end
      else if (clkEn)
      begin
         adcStart_r    <= 1'b0;
         resultValid_r <= 1'b0;
         if (paceCnt_r != '0)
            paceCnt_r <= paceCnt_r - PACE_W'(1);
         if (rdResult)
            resFull_r <= 1'b0;
         case (state_r)
            ST_IDLE:
               if (goReq && listLen_r != 8'h00)
               begin
                  idx_r   <= 8'h00;
                  state_r <= ST_FETCH;
               end
            ST_FETCH:
            begin
               taken_r  <= 15'h0000;
               target_r <= entTarget; // R1 R6
               pace_r   <= entPace;
               lcr_r    <= lcrActive;
               if (isDigital)
               begin
                  resultData_r <= dinS2_r; // R2
                  state_r      <= ST_EMIT;
               end
               else
               begin
                  adcChannel_r <= entry[ENT_CH_LSB +: 8];
                  adcGain_r    <= entry[ENT_GN_LSB +: 3];
                  state_r      <= ST_START;
               end
            end
            ST_START:
               if (paceCnt_r == '0)
               begin
                  adcStart_r <= 1'b1; // R4
                  paceCnt_r  <= pace_r - PACE_W'(1); // R8
                  state_r    <= ST_WAIT;
               end
            ST_WAIT:
               if (doneEdge)
               begin
                  taken_r <= taken_r + OS_ONE;
                  state_r <= lastSamp ? ST_DIV : ST_START;
               end
            ST_DIV:
               if (acc.done)
               begin
                  resultData_r <= acc.avg; // R5
                  state_r      <= ST_EMIT;
               end
            ST_EMIT:
            begin
               resultValid_r <= 1'b1;
               resultIndex_r <= idx_r;
               resReg_r      <= resultData_r;
               resFull_r     <= 1'b1;
               idx_r         <= idx_r + 8'h01;
               state_r       <= lastEntry ? ST_IDLE : ST_FETCH;
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   // ============================================================
   // Checks
   default clocking cb @(posedge clock iff clkEn); endclocking
   default disable iff (!reset_n);

   sequence sDivDone;
      state_r == ST_DIV && acc.done;
   endsequence
   sequence sEmitOut;
      state_r == ST_EMIT ##1 resultValid_r;
   endsequence

   a_os_range: assert property (osEn && state_r != ST_IDLE && state_r != ST_FETCH
      |-> target_r >= OS_MIN && target_r <= OS_MAX) else $error("oversampling out of range"); // R3
   a_every_analog: assert property (state_r == ST_FETCH && osEn && !isDigital && !lcrActive
      |=> target_r == osClamp) else $error("analog entry not oversampled"); // R1
   a_single_conv: assert property (state_r == ST_FETCH && !osEn
      |=> target_r == OS_ONE) else $error("more than one conversion"); // R6
   a_digital_bypass: assert property (state_r == ST_FETCH && isDigital
      |=> state_r == ST_EMIT && resultData_r == $past(dinS2_r)) else $error("digital not bypassed"); // R2
   a_chan_hold: assert property (state_r == ST_WAIT && !(doneEdge && lastSamp)
      |=> $stable(adcChannel_r) && $stable(adcGain_r)) else $error("channel changed in entry"); // R4
   a_lcr_pow2: assert property (lcr_r && state_r == ST_WAIT
      |-> (target_r & (target_r - OS_ONE)) == 15'h0000) else $error("line count not power of two"); // R7
   a_lcr_pace: assert property (lcr_r && adcStart_r
      |-> paceCnt_r == (mainsCyc >> floorLog2(target_r)) - PACE_W'(1)) else $error("pacing wrong"); // R8
   a_result_path: assert property (sDivDone |=> sEmitOut) else $error("average not delivered"); // R5
   a_start_pulse: assert property (adcStart_r |=> !adcStart_r ##0 state_r == ST_WAIT)
      else $error("start not one cycle"); // R4

endmodule : osa_scan_averager

// ---- osa_adc_model.sv ----
// Behavioural model of the multiplexed converter front end
`timescale 1ns/1ps
module osa_adc_model
(
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic       slowMode,
   input  wire logic       adcStart,
   input  wire logic [7:0] adcChannel,
   input  wire logic [2:0] adcGain,
   output logic            adcConvDone,
   output logic [15:0]     adcData,
   output int              runLen,
   output logic [7:0]      runCh,
   output logic [2:0]      runGn,
   output int              gapMin,
   output int              gapMax,
   output int              startTotal
);
   int          waitCnt;
   int          holdCnt;
   int          since;
   logic [15:0] pend;
   logic        newRun;

   // ============================================================
   // Sample values and run tracking
   function automatic logic [15:0] sampleOf(input logic [7:0] ch, input int idx);
      return 16'(int'(ch) * 40 - 400 + ((idx % 2) ? -2 : 3));
   endfunction : sampleOf

   // A run restarts whenever channel or gain moves
   assign newRun = (runLen == 0) || (adcChannel !== runCh) || (adcGain !== runGn);

   // ============================================================
   // Conversion timing; data inverted once the hold has run out
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         waitCnt <= 0;
         holdCnt <= 0;
         adcConvDone <= 1'b0;
         adcData <= 16'h5A5A;
         runLen <= 0;
         startTotal <= 0;
         since <= 0;
      end
      else
      begin
         since <= since + 1;
         if (adcStart)
         begin
            waitCnt <= slowMode ? 20 : 2;
            startTotal <= startTotal + 1;
            since <= 1;
            runCh <= adcChannel;
            runGn <= adcGain;
            pend <= sampleOf(adcChannel, newRun ? 0 : runLen);
            runLen <= newRun ? 1 : runLen + 1;
            gapMin <= newRun ? 1000000 : ((since < gapMin) ? since : gapMin);
            gapMax <= newRun ? 0 : ((since > gapMax) ? since : gapMax);
         end
         else if (waitCnt > 1)
            waitCnt <= waitCnt - 1;
         else if (waitCnt == 1)
         begin
            waitCnt <= 0;
            adcData <= pend;
            holdCnt <= 6;
         end
         if (holdCnt > 0)
         begin
            holdCnt <= holdCnt - 1;
            adcConvDone <= (holdCnt > 1);
            if (holdCnt == 1)
               adcData <= ~adcData;
         end
      end
   end
endmodule : osa_adc_model

// ---- oversampling_scan_averager_bench.sv ----
// Self-checking bench of the oversampling scan averager
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; $display("[ERR] %0t got %0h want %0h", $time, a, e); end end
module oversampling_scan_averager_bench;
   import osa_pkg::*;
   typedef struct {logic [15:0] d; logic [7:0] ix; int len; logic [7:0] ch; logic [2:0] gn; int gMin; int gMax; int tot;} osa_cap_t;
   localparam int CONVS = 8;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic        slowMode = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [15:0] dinPins = 16'h3CA5;
   wire         hreadyout, hresp, adcStart, adcConvDone, resultValid;
   wire  [31:0] hrdata;
   wire  [7:0]  adcChannel, resultIndex;
   wire  [2:0]  adcGain;
   wire  [15:0] adcData, resultData;
   int          runLen, gapMin, gapMax, startTotal, n_mismatch = 0, check_count = 0, nEnt;
   logic [7:0]  runCh;
   logic [2:0]  runGn;
   logic [7:0]  chBase = 8'h01;
   osa_kind_t   kinds[8];
   int          expN[8];
   int          pace[8];
   osa_cap_t    capQ[$];

   // ============================================================
   // Design, converter model and clock
   osa_scan_averager #(.MAINS50_CYCLES(4096), .MAINS60_CYCLES(3000), .CONV_CYCLES(CONVS)) dut (.clock(clock),
      .reset_n(reset_n), .clkEn(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .adcStart(adcStart), .adcChannel(adcChannel), .adcGain(adcGain), .adcConvDone(adcConvDone), .adcData(adcData),
      .dinPins(dinPins), .resultValid(resultValid), .resultData(resultData), .resultIndex(resultIndex));
   osa_adc_model adc (.clock(clock), .reset_n(reset_n), .slowMode(slowMode), .adcStart(adcStart),
      .adcChannel(adcChannel), .adcGain(adcGain), .adcConvDone(adcConvDone), .adcData(adcData), .runLen(runLen),
      .runCh(runCh), .runGn(runGn), .gapMin(gapMin), .gapMax(gapMax), .startTotal(startTotal));
   always #2.5 clock = ~clock;
   always @(posedge clock)
      if (resultValid === 1'b1)
         capQ.push_back('{resultData, resultIndex, runLen, runCh, runGn, gapMin, gapMax, startTotal});

   // ============================================================
   // Verdict, bus cycles and expected averages
   task automatic tally_and_finish;
      if (n_mismatch == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish

   task automatic waitRdy;
      int k = 0;
      do
         @(posedge clock);
      while (hreadyout !== 1'b1 && ++k < 64);
      if (k >= 64)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask : waitRdy

   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      hwrite <= wr;
      htrans <= HTRANS_NONSEQ;
      waitRdy();
      htrans <= 2'h0;
      hwdata <= wd;
      waitRdy();
      rd = hrdata;
      `CHK(hresp, HRESP_OKAY)
   endtask : bus

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wr

   task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      `CHK(x, e)
   endtask : rdChk

   function automatic logic [15:0] expAvg(input logic [7:0] ch, input int n);
      int s = 0;
      int sh = $clog2(n);
      for (int i = 0; i < n; i++)
         s += int'(ch) * 40 - 400 + ((i % 2) ? -2 : 3);
      return ((1 << sh) == n) ? 16'(s >>> sh) : 16'(s / n);
   endfunction : expAvg

   function automatic logic [2:0] gainOf(input int i);
      return (i > 0 && kinds[i] == KIND_AZ) ? 3'(i) : 3'(i + 1);
   endfunction : gainOf

   task automatic ent(input int i, input osa_kind_t k, input int n, input int p);
      kinds[i] = k;
      expN[i] = n;
      pace[i] = p;
   endtask : ent

   // ============================================================
   // One scan: program list, start, check each result
   task automatic scan(input int n, input logic [31:0] ctrl, input logic [31:0] fac);
      osa_cap_t c;
      int k = 0;
      int prev;
      nEnt = n;
      capQ.delete();
      dinPins <= dinPins ^ 16'h0F0F;
      wr(OFS_OSCNT, fac);
      wr(OFS_LEN, 32'(nEnt));
      for (int i = 0; i < nEnt; i++)
         wr(12'h100 + 12'(4 * i), {17'h0, kinds[i], 1'b0, gainOf(i), chBase + 8'(i)});
      prev = startTotal;
      wr(OFS_CTRL, ctrl | 32'h1);
      while (capQ.size() < nEnt && k++ < 40000)
         @(posedge clock);
      if (k >= 40000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
      for (int i = 0; i < nEnt; i++)
      begin
         c = capQ[i];
         `CHK(c.ix, 8'(i))
         if (kinds[i] == KIND_DIG)
         begin
            `CHK(c.d, dinPins)
            `CHK(c.tot, prev)
            continue;
         end
         `CHK(c.ch, chBase + 8'(i))
         `CHK(c.gn, gainOf(i))
         `CHK(c.len, expN[i])
         `CHK(c.tot, prev + expN[i])
         `CHK(c.d, expAvg(chBase + 8'(i), expN[i]))
         if (pace[i] > 0)
            `CHK(c.gMin + c.gMax, 2 * pace[i])
         else if (expN[i] > 1)
            `CHK(c.gMin >= CONVS, 1'b1)
         prev = c.tot;
      end
      chBase = chBase + 8'h08;
   endtask : scan

   // ============================================================
   // Main sequence
   initial
   begin
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      rdChk(OFS_CTRL, 32'h0);
      rdChk(OFS_OSCNT, 32'h2);
      rdChk(OFS_LEN, 32'h1);
      rdChk(OFS_RESULT, 32'h0);
      wr(12'h0FC, 32'hFFFFFFFF);
      rdChk(12'h0FC, 32'h0);
      wr(12'h200, 32'hFFFF8001);
      wr(12'h23C, 32'h00007FFE);
      rdChk(12'h200, 32'h00008001);
      rdChk(12'h23C, 32'h00007FFE);
      wr(OFS_OSCNT, 32'h4000);
      rdChk(OFS_OSCNT, 32'h4000);
      ent(0, KIND_VOLT, 2, 0);
      ent(1, KIND_AZ, 2, 0);
      scan(2, 32'h1 << CTRL_OS, 32'h1);
      ent(1, KIND_TC, 1, 0);
      ent(2, KIND_DIG, 0, 0);
      ent(0, KIND_VOLT, 1, 0);
      scan(3, 32'h0, 32'h5);
      rdChk(OFS_RESULT, {16'h0, dinPins});
      slowMode <= 1'b1;
      ent(0, KIND_VOLT, 3, 0);
      ent(1, KIND_TC, 3, 0);
      ent(2, KIND_CJ, 3, 0);
      ent(3, KIND_DIG, 0, 0);
      ent(4, KIND_AZ, 3, 0);
      scan(5, 32'h1 << CTRL_OS, 32'h3);
      slowMode <= 1'b0;
      ent(0, KIND_VOLT, 4, 1024);
      ent(1, KIND_TC, 4, 1024);
      scan(2, (32'h1 << CTRL_OS) | (32'h1 << CTRL_LCR), 32'h5);
      ent(0, KIND_VOLT, 8, 0);
      ent(1, KIND_TC, 8, 375);
      ent(2, KIND_DIG, 0, 0);
      scan(3, 32'h1E, 32'h8);
      rdChk(OFS_STAT, 32'h0000_0302);
      tally_and_finish();
   end
endmodule : oversampling_scan_averager_bench
